// ### logic/tlbt_array.sv
// tag cam, physical ram and replacement pointer of the buffer
`timescale 1ns/1ps
module tlbt_array
    import tlbt_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    // fill port
    tlbt_fill_if.dst                    fill,
    // search port
    input  wire logic                   look_i,
    input  wire logic [LIN_W-1:0]       look_lin_i,
    input  wire logic [TAG_W-1:0]       look_tag_i,
    output logic                        hit_o,
    output logic [PHYS_W-1:0]           hit_phys_o,
    output logic [PTR_W-1:0]            ptr_o
);
    localparam int WAYS = ENTRIES / SETS;
    localparam int WAY_W = $clog2(WAYS);

    logic [LIN_W-1:0]  cam_lin  [ENTRIES];
    logic [TAG_W-1:0]  cam_tag  [ENTRIES];
    logic [PHYS_W-1:0] ram_phys [ENTRIES];
    logic [ENTRIES-1:0] vld_reg;
    logic [PTR_W-1:0]  ptr_reg;
    logic [WAY_W-1:0]  slot_reg [SETS];
    logic [PTR_W-1:0]  set_w;
    logic [IDX_W-1:0]  widx;

    // attribute pair match: both low misses, both high forces hit
    function automatic logic pair_ok(input logic [1:0] q,
                                     input logic [1:0] e);
        pair_ok = (q == 2'b11) ? 1'b1 :
                  (q == 2'b00) ? 1'b0 : (q == e);
    endfunction : pair_ok

    // chosen set: software value or the internal pointer
    assign set_w = fill.use_sel ? fill.sel : ptr_reg;
    assign widx  = {set_w, slot_reg[set_w]};

    // storage; data only, so no reset needed on the arrays
    always_ff @(posedge clk_i) begin
        if (fill.we) begin
            cam_lin[widx]  <= fill.lin;
            cam_tag[widx]  <= fill.tag;
            ram_phys[widx] <= fill.phys;
        end
    end

    // per-set round robin slot and entry presence
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vld_reg <= '0;
            for (int s = 0; s < SETS; s++) begin
                slot_reg[s] <= '0;
            end
        end else if (fill.we) begin
            vld_reg[widx]  <= 1'b1;
            slot_reg[set_w] <= slot_reg[set_w] + 3'h1;
        end
    end

    // full associative compare; among duplicates the highest index wins
    always_comb begin
        hit_o      = 1'b0;
        hit_phys_o = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (vld_reg[i] && cam_lin[i] == look_lin_i &&
                cam_tag[i][VALID_BIT] && look_tag_i[VALID_BIT] &&
                pair_ok(look_tag_i[5:4], cam_tag[i][5:4]) &&
                pair_ok(look_tag_i[3:2], cam_tag[i][3:2]) &&
                pair_ok(look_tag_i[1:0], cam_tag[i][1:0])) begin
                hit_o      = 1'b1;
                hit_phys_o = ram_phys[i];
            end
        end
    end

    // pointer steps as a wrapping counter on each hit while look_i is high
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ptr_reg <= '0;
        end else if (look_i && hit_o) begin
            ptr_reg <= ptr_reg + 2'h1;
        end
    end
    assign ptr_o = ptr_reg;
endmodule : tlbt_array

// ### logic/tlbt_fill_if.sv
// interface carrying a buffer fill from the test port or the walker to the array
`timescale 1ns/1ps
interface tlbt_fill_if;
    import tlbt_pkg::*;
    logic                 we;
    logic [LIN_W-1:0]     lin;
    logic [TAG_W-1:0]     tag;
    logic [PHYS_W-1:0]    phys;
    logic                 use_sel;
    logic [PTR_W-1:0]     sel;
    modport src (output we, lin, tag, phys, use_sel, sel);
    modport dst (input  we, lin, tag, phys, use_sel, sel);
endinterface : tlbt_fill_if

// ### logic/tlbt_pkg.sv
// package of constants and types for the tlb test access port
package tlbt_pkg;
    // ------------------------------------------------------------
    // buffer geometry
    // ------------------------------------------------------------
    localparam int ENTRIES    = 32;
    localparam int SETS       = 4;
    localparam int PTR_W      = 2;
    localparam int IDX_W      = 5;
    localparam int LIN_W      = 20;
    localparam int PHYS_W     = 20;
    localparam int OFS_W      = 12;
    localparam int TAG_W      = 7;
    localparam int DATA_W     = 32;

    // ------------------------------------------------------------
    // register numbers and field positions
    // ------------------------------------------------------------
    localparam logic [2:0] REG_CMD_NUM  = 3'h6;
    localparam logic [2:0] REG_DATA_NUM = 3'h7;
    localparam int CMD_OP_BIT   = 0;
    localparam int TAG_LO       = 5;
    localparam int TAG_HI       = 11;
    localparam int VALID_BIT    = 6;  // within the tag field
    localparam int ADDR_LO      = 12;
    localparam int ADDR_HI      = 31;
    localparam int DAT_SEL_BIT  = 4;
    localparam int DAT_HIT_BIT  = 4;
    localparam int DAT_PTR_LO   = 2;
    localparam int DAT_PTR_HI   = 3;
    localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // sequencer states, gray along idle-directory-table-fill
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TLBT_IDLE = 2'b00,
        TLBT_DIR  = 2'b01,
        TLBT_TBL  = 2'b11,
        TLBT_FILL = 2'b10
    } tlbt_state_e;
endpackage : tlbt_pkg

// ### logic/tlbt_top.sv
// tlb test access port with translation and miss walker
`timescale 1ns/1ps
// Operation
// - 32-entry cam of linear address and tags
// - ram word holds upper 20 physical bits
// - four sets, 2-bit pointer picks fill set
// - hit joins 20 physical bits and offset
// - miss walks directory, table, then fills buffer
// - two 32-bit test registers, move access
// - register 6 command, register 7 data
// - command write launches; bit0 one is lookup
// - write stores data and command into entry
// - lookup copies address, sets or clears hit
// - tag field valid bit 11 down to 5
// - pair both low misses, both high hits
// - pointer updates after every hit
// - data bit4 selects bits 3:2 over pointer
// - lookup fills bits 4-2; address only on hit
module tlbt_top
    import tlbt_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    // test register move port
    input  wire logic                   treg_wr_i,
    input  wire logic [2:0]             treg_num_i,
    input  wire logic [DATA_W-1:0]      treg_wdata_i,
    output logic [DATA_W-1:0]           treg_rdata_o,
    // translation request
    input  wire logic                   xl_req_i,
    input  wire logic [DATA_W-1:0]      xl_lin_i,
    input  wire logic                   xl_user_i,
    input  wire logic                   xl_write_i,
    output logic                        xl_busy_o,
    output logic                        xl_done_o,
    output logic [DATA_W-1:0]           xl_phys_o,
    // page walk memory read
    output logic                        mem_req_o,
    output logic [DATA_W-1:0]           mem_addr_o,
    input  wire logic                   mem_ack_i,
    input  wire logic [DATA_W-1:0]      mem_rdata_i,
    // directory base for the walk
    input  wire logic [PHYS_W-1:0]      dir_base_i
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    // walk fields of the linear address and of the fetched entries
    localparam logic [1:0] PTE_IDX_LO = 2'h0;
    localparam int DIR_HI     = 31;
    localparam int DIR_LO     = 22;
    localparam int TBL_HI     = 21;
    localparam int TBL_LO     = 12;
    localparam int USER_BIT   = 2;
    localparam int WRITE_BIT  = 1;
    localparam int DIRTY_BIT  = 6;
    localparam int ATTR_LO    = 0;

    // command word: page in 31:12, valid in 11, then the dirty, user
    //   and write pairs, each with its complement, down to bit 5;
    //   bit 0 set asks for a lookup, clear for an entry write
    // data word: page in 31:12, bit 4 hit flag or set select,
    //   3:2 pointer after a lookup or the chosen set for a write

    tlbt_fill_if      fill_bus ();
    tlbt_state_e      st_reg, st_next;
    logic [DATA_W-1:0] cmd_reg;
    logic [DATA_W-1:0] data_reg;
    logic [DATA_W-1:0] lin_reg;
    logic [PHYS_W-1:0] pte_reg;
    logic              mreq_reg;
    logic [DATA_W-1:0] maddr_reg;
    logic              done_reg;
    logic [DATA_W-1:0] xphys_reg;
    logic              cmd_wr;
    logic              data_wr;
    logic              look_test;
    logic              look_xl;
    logic [LIN_W-1:0]  look_lin;
    logic [TAG_W-1:0]  look_tag;
    logic              hit;
    logic [PHYS_W-1:0] hit_phys;
    logic [PTR_W-1:0]  ptr;
    logic              walk_fill;
    logic [TAG_W-1:0]  walk_tag;
    logic [PTR_W-1:0]  ptr_after;
    logic              dirty_reg;
    logic              walk_start;
    logic              dir_ack;
    logic              tbl_ack;

    // page field of a register or memory word
    function automatic logic [PHYS_W-1:0] page_of(
        input logic [DATA_W-1:0] w);
        page_of = w[ADDR_HI:ADDR_LO];
    endfunction : page_of

    // tag field of a command word
    function automatic logic [TAG_W-1:0] tag_of(input logic [DATA_W-1:0] w);
        tag_of = w[TAG_HI:TAG_LO];
    endfunction : tag_of

    // command kind: bit 0 set asks for a lookup, clear for a write
    function automatic logic cmd_is_lookup(input logic [DATA_W-1:0] w);
        cmd_is_lookup = w[CMD_OP_BIT];
    endfunction : cmd_is_lookup

    // tag of a walked entry: valid, then each right and its complement
    function automatic logic [TAG_W-1:0] walk_tag_of(
        input logic d, input logic u, input logic w);
        walk_tag_of = {1'b1, d, ~d, u, ~u, w, ~w};
    endfunction : walk_tag_of

    // ------------------------------------------------------------
    // register access decode
    // ------------------------------------------------------------
    assign cmd_wr  = treg_wr_i && treg_num_i == REG_CMD_NUM;
    assign data_wr = treg_wr_i && treg_num_i == REG_DATA_NUM;

    // lookup launched by a command write with bit 0 set
    assign look_test = cmd_wr && cmd_is_lookup(treg_wdata_i);
    // normal translation only searches while idle
    assign look_xl   = xl_req_i && st_reg == TLBT_IDLE && !cmd_wr;

    // search key comes from the new command or from translation
    always_comb begin
        if (cmd_wr) begin
            look_lin = page_of(treg_wdata_i);
            look_tag = tag_of(treg_wdata_i);
        end else begin
            look_lin = page_of(xl_lin_i);
            // hits need valid; a set user or write request bit forces that pair, a clear one needs a clear entry bit
            look_tag = {1'b1, 2'b11, xl_user_i, 1'b1,
                        xl_write_i, 1'b1};
        end
    end

    // ------------------------------------------------------------
    // buffer array
    // ------------------------------------------------------------
    tlbt_array u_array (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .fill       (fill_bus.dst),
        .look_i     (look_test || look_xl),
        .look_lin_i (look_lin),
        .look_tag_i (look_tag),
        .hit_o      (hit),
        .hit_phys_o (hit_phys),
        .ptr_o      (ptr)
    );

    // pointer value once this lookup is done; a hit steps it
    assign ptr_after = hit ? ptr + 2'h1 : ptr;

    // fill source: a test write command or a finished walk
    assign walk_fill = st_reg == TLBT_FILL;
    assign walk_tag  = walk_tag_of(dirty_reg, pte_reg[USER_BIT],
                                   pte_reg[WRITE_BIT]);
    assign fill_bus.we = (cmd_wr && !cmd_is_lookup(treg_wdata_i))
                         || walk_fill;
    assign fill_bus.lin = cmd_wr ? page_of(treg_wdata_i)
                                 : page_of(lin_reg);
    assign fill_bus.tag = cmd_wr ? tag_of(treg_wdata_i)
                                 : walk_tag;
    // a walk fill takes the captured entry unless a command write shares its cycle; the read bus is stale by then
    assign fill_bus.phys = cmd_wr ? page_of(data_reg)
                                  : page_of(xphys_reg);
    // walk fills take the internal pointer unless a command write in the same cycle has data bit 4 set
    assign fill_bus.use_sel = cmd_wr && data_reg[DAT_SEL_BIT];
    assign fill_bus.sel = data_reg[DAT_PTR_HI:DAT_PTR_LO];

    // ------------------------------------------------------------
    // test registers
    // ------------------------------------------------------------
    // command register keeps exactly what was written
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_reg <= REG_RESET;
        end else if (cmd_wr) begin
            cmd_reg <= treg_wdata_i;
        end
    end

    // data register: software load or lookup result
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_reg <= REG_RESET;
        end else if (data_wr) begin
            data_reg <= treg_wdata_i;
        end else if (look_test) begin
            data_reg[DAT_HIT_BIT] <= hit;
            // result pointer shows the value after this lookup
            data_reg[DAT_PTR_HI:DAT_PTR_LO] <= ptr_after;
            // on a miss the address bits are left as they were
            if (hit) begin
                data_reg[ADDR_HI:ADDR_LO] <= hit_phys;
            end
        end
    end

    // read mux for register moves
    always_comb begin
        case (treg_num_i)
            REG_CMD_NUM:  treg_rdata_o = cmd_reg;
            REG_DATA_NUM: treg_rdata_o = data_reg;
            default:      treg_rdata_o = REG_RESET;
        endcase
    end

    // ------------------------------------------------------------
    // miss walker
    // ------------------------------------------------------------
    // walk events
    assign walk_start = look_xl && !hit;
    assign dir_ack    = st_reg == TLBT_DIR && mem_ack_i;
    assign tbl_ack    = st_reg == TLBT_TBL && mem_ack_i;

    // next state; test commands win over translation requests
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            TLBT_IDLE: begin
                if (look_xl && !hit) begin
                    st_next = TLBT_DIR;
                end
            end
            TLBT_DIR: begin
                if (mem_ack_i) begin
                    st_next = TLBT_TBL;
                end
            end
            TLBT_TBL: begin
                if (mem_ack_i) begin
                    st_next = TLBT_FILL;
                end
            end
            TLBT_FILL: begin
                st_next = TLBT_IDLE;
            end
            default: begin
                st_next = TLBT_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= TLBT_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // walk request: raised on a miss, held until the table ack
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mreq_reg <= 1'b0;
        end else if (walk_start) begin
            mreq_reg <= 1'b1;
        end else if (tbl_ack) begin
            mreq_reg <= 1'b0;
        end
    end

    // walk address: directory entry first, then the table entry
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            maddr_reg <= REG_RESET;
        end else if (walk_start) begin
            maddr_reg <= {dir_base_i, xl_lin_i[DIR_HI:DIR_LO],
                          PTE_IDX_LO};
        end else if (dir_ack) begin
            maddr_reg <= {page_of(mem_rdata_i),
                          lin_reg[TBL_HI:TBL_LO], PTE_IDX_LO};
        end
    end

    // linear address of the walk, kept for the fill
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lin_reg <= REG_RESET;
        end else if (walk_start) begin
            lin_reg <= xl_lin_i;
        end
    end

    // directory entry; only its low rights bits are used later
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pte_reg <= '0;
        end else if (dir_ack) begin
            pte_reg <= page_of(mem_rdata_i);
            // directory attribute bits kept low
            pte_reg[USER_BIT:ATTR_LO] <= mem_rdata_i[USER_BIT:ATTR_LO];
        end
    end

    // dirty bit of the table entry; the read bus is stale at the fill
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dirty_reg <= 1'b0;
        end else if (tbl_ack) begin
            dirty_reg <= mem_rdata_i[DIRTY_BIT];
        end
    end

    // translation answer: one-cycle done with the joined address
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_reg  <= 1'b0;
            xphys_reg <= REG_RESET;
        end else begin
            done_reg <= 1'b0;
            if (look_xl && hit) begin
                done_reg  <= 1'b1;
                xphys_reg <= {hit_phys, xl_lin_i[OFS_W-1:0]};
            end else if (st_reg == TLBT_TBL && mem_ack_i) begin
                done_reg  <= 1'b1;
                xphys_reg <= {mem_rdata_i[ADDR_HI:ADDR_LO],
                              lin_reg[OFS_W-1:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign xl_busy_o  = st_reg != TLBT_IDLE || cmd_wr;
    assign xl_done_o  = done_reg;
    assign xl_phys_o  = xphys_reg;
    assign mem_req_o  = mreq_reg;
    assign mem_addr_o = maddr_reg;
endmodule : tlbt_top

// ### verif/test_tlbt_top.sv
// self-checking bench for the tlb test access port
`timescale 1ns/1ps
module test_tlbt_top;
    import tlbt_pkg::*;
    // --------------------------------------------------------------
    // signals and stimulus tables
    // --------------------------------------------------------------
    logic              clk_i, nrst_i, treg_wr_i, xl_req_i, mem_ack_i;
    logic [2:0]        treg_num_i;
    logic [DATA_W-1:0] treg_wdata_i, xl_lin_i, mem_rdata_i, v;
    logic [DATA_W-1:0] treg_rdata_o, xl_phys_o, mem_addr_o;
    logic              xl_busy_o, xl_done_o, mem_req_o;
    logic [PHYS_W-1:0] dir_base_i;
    int                n_errors, n_tests, p;
    localparam logic [19:0] L1 = 20'h12345, L2 = 20'h0abcd, L3 = 20'h55555;
    localparam logic [19:0] P1 = 20'h8f00d, P2 = 20'h00777;
    localparam logic [11:0] TG = 12'hb40; // valid, clean, user, writable
    localparam logic [31:0] LW = 32'h0246_8678;
    // read-only directory rights, so a supervisor read hits the entry
    localparam logic [31:0] PDE = 32'h0005_5001, PTE = 32'h0009_9047;
    // lookups: exact, exact, dirty pair low, user pair high, absent, exact
    logic [19:0] lk_lin [6] = '{L1, L2, L1, L2, L3, L1};
    logic [11:0] lk_tag [6] = '{TG, TG, 12'h940, 12'hbc0, TG, TG};
    logic        lk_hit [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [19:0] lk_phy [6] = '{P1, P2, P1, P2, P1, P1};

    // user and write attributes tied: the walk sets the entry's rights
    tlbt_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .treg_wr_i(treg_wr_i),
        .treg_num_i(treg_num_i), .treg_wdata_i(treg_wdata_i),
        .treg_rdata_o(treg_rdata_o), .xl_req_i(xl_req_i),
        .xl_lin_i(xl_lin_i), .xl_user_i(1'b0), .xl_write_i(1'b0),
        .xl_busy_o(xl_busy_o), .xl_done_o(xl_done_o),
        .xl_phys_o(xl_phys_o), .mem_req_o(mem_req_o),
        .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
        .mem_rdata_i(mem_rdata_i), .dir_base_i(dir_base_i));

    // 100 mhz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic check(input logic [DATA_W-1:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("compares %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    // register move write, one cycle wide, inputs change at negedge
    task automatic wr(input logic [2:0] num, input logic [DATA_W-1:0] d);
        @(negedge clk_i);
        treg_wr_i = 1'b1;
        treg_num_i = num;
        treg_wdata_i = d;
        @(negedge clk_i);
        treg_wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] num, output logic [DATA_W-1:0] d);
        @(negedge clk_i);
        treg_num_i = num;
        #1 d = treg_rdata_o;
    endtask : rd
    // bounded wait; running out ends the run as a mismatch
    task automatic wait_hi(ref logic s, input int lim);
        for (int k = 0; k < lim && s !== 1'b1; k++) @(negedge clk_i);
        if (s !== 1'b1) begin
            n_errors++;
            $display("FAIL t=%0t wait ran out", $time);
            end_sim();
        end
    endtask : wait_hi
    task automatic mem_step(input logic [DATA_W-1:0] a, r);
        wait_hi(mem_req_o, 20);
        check(mem_addr_o, a);
        // one wait state: the request must hold without an ack
        @(negedge clk_i);
        mem_ack_i = 1'b1;
        mem_rdata_i = r;
        @(negedge clk_i);
        mem_ack_i = 1'b0;
        mem_rdata_i = ~r; // stale bus after ack, never the last value
    endtask : mem_step
    task automatic xlate(input logic [DATA_W-1:0] ph, input bit walk);
        @(negedge clk_i);
        xl_req_i = 1'b1;
        xl_lin_i = LW;
        if (walk) begin
            mem_step({dir_base_i, LW[31:22], 2'b00}, PDE);
            mem_step({PDE[31:12], LW[21:12], 2'b00}, PTE);
        end
        wait_hi(xl_done_o, walk ? 20 : 2);
        check(xl_phys_o, ph);
        check({31'h0, mem_req_o}, 32'h0);
        xl_req_i = 1'b0;
    endtask : xlate

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        {n_errors, n_tests, p} = '0;
        {nrst_i, treg_wr_i, xl_req_i, mem_ack_i, treg_num_i} = '0;
        {treg_wdata_i, xl_lin_i, mem_rdata_i} = '0;
        dir_base_i = 20'habcde;
        repeat (6) @(negedge clk_i);
        nrst_i = 1'b1;
        // reset contents and unused numbers
        for (int n = 0; n < 8; n++) begin
            rd(n[2:0], v);
            check(v, REG_RESET);
        end
        // one entry by explicit set 3, one by the pointer
        wr(REG_DATA_NUM, {P1, 12'h01c});
        wr(REG_CMD_NUM, {L1, TG});
        rd(REG_CMD_NUM, v);
        check(v, {L1, TG});
        wr(REG_DATA_NUM, {P2, 12'h000});
        wr(REG_CMD_NUM, {L2, TG});
        // lookups; a walk and a translation hit go before the last one
        for (int n = 0; n < 6; n++) begin
            if (n == 5) begin
                xlate({PTE[31:12], LW[11:0]}, 1'b1);
                xlate({PTE[31:12], LW[11:0]}, 1'b0);
                p = (p + 1) % 4;
            end
            wr(REG_CMD_NUM, {lk_lin[n], lk_tag[n] | 12'h001});
            if (lk_hit[n]) p = (p + 1) % 4;
            rd(REG_DATA_NUM, v);
            check({29'h0, v[4:2]}, {29'h0, lk_hit[n], p[1:0]});
            if (lk_hit[n]) begin
                check({12'h0, v[31:12]}, {12'h0, lk_phy[n]});
            end
        end
        end_sim();
    end
endmodule : test_tlbt_top

// ### verif/tlbt_monitor.sv
// assertion checker for the tlb test access port, bound to the top
`timescale 1ns/1ps
module tlbt_monitor
    import tlbt_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   nrst_i,
    // test register port
    input  wire logic                   treg_wr_i,
    input  wire logic [2:0]             treg_num_i,
    input  wire logic [DATA_W-1:0]      treg_wdata_i,
    input  wire logic [DATA_W-1:0]      treg_rdata_o,
    // translation and walk
    input  wire logic                   xl_req_i,
    input  wire logic [DATA_W-1:0]      xl_lin_i,
    input  wire logic                   xl_busy_o,
    input  wire logic                   xl_done_o,
    input  wire logic [DATA_W-1:0]      xl_phys_o,
    input  wire logic                   mem_req_o,
    input  wire logic [DATA_W-1:0]      mem_addr_o,
    input  wire logic                   mem_ack_i,
    input  wire logic [PHYS_W-1:0]      dir_base_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // --------------------------------------------------------------
    // helper logic
    // --------------------------------------------------------------
    logic              cmd_wr;
    logic [DATA_W-1:0] cmd_shadow_reg;
    assign cmd_wr = treg_wr_i && (treg_num_i == REG_CMD_NUM);

    // last command word, kept apart from any command side effect
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_shadow_reg <= REG_RESET;
        end else if (cmd_wr) begin
            cmd_shadow_reg <= treg_wdata_i;
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    chk_cmd_readback: assert property (
        treg_num_i == REG_CMD_NUM |-> treg_rdata_o == cmd_shadow_reg)
        else $error("command register read differs from last write");
    chk_data_write: assert property (
        treg_wr_i && treg_num_i == REG_DATA_NUM |=>
        treg_num_i != REG_DATA_NUM || treg_rdata_o == $past(treg_wdata_i))
        else $error("data register did not take the written word");
    chk_other_zero: assert property (
        treg_num_i < REG_CMD_NUM |-> treg_rdata_o == '0)
        else $error("unused register number read nonzero");
    chk_cmd_busy: assert property (
        cmd_wr |-> xl_busy_o)
        else $error("command write did not show busy");
    chk_done_pulse: assert property (
        xl_done_o |=> !xl_done_o)
        else $error("done held longer than one cycle");
    chk_phys_held: assert property (
        !xl_done_o |-> $stable(xl_phys_o))
        else $error("physical address moved without done");
    chk_offset_join: assert property (
        xl_done_o |-> xl_phys_o[OFS_W-1:0] == xl_lin_i[OFS_W-1:0])
        else $error("offset bits not passed through");
    chk_walk_dir: assert property (
        $rose(mem_req_o) |->
        mem_addr_o == {dir_base_i, xl_lin_i[31:22], 2'b00})
        else $error("directory read address wrong");
    chk_mem_hold: assert property (
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("walk read dropped or moved before ack");
    chk_hit_or_walk: assert property (
        xl_req_i && !xl_busy_o && !mem_req_o && !xl_done_o && !treg_wr_i
        |=> xl_done_o ^ mem_req_o)
        else $error("taken request neither answered nor walked");

    // --------------------------------------------------------------
    // coverage of main scenarios
    // --------------------------------------------------------------
    cov_lookup: cover property (cmd_wr && treg_wdata_i[CMD_OP_BIT]);
    cov_walk: cover property (mem_req_o && mem_ack_i);
    cov_done: cover property (xl_done_o && !$past(mem_ack_i));
endmodule : tlbt_monitor

bind tlbt_top tlbt_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i),
    .treg_wr_i(treg_wr_i), .treg_num_i(treg_num_i),
    .treg_wdata_i(treg_wdata_i), .treg_rdata_o(treg_rdata_o),
    .xl_req_i(xl_req_i), .xl_lin_i(xl_lin_i), .xl_busy_o(xl_busy_o),
    .xl_done_o(xl_done_o), .xl_phys_o(xl_phys_o), .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
    .dir_base_i(dir_base_i));
